/* File: core/chg_pkg.sv */
// package with constants and carriers for the charger switch and fault control
// What this block does
// - high side on while error exceeds ramp; then low side until ramp resets.
// - dead time with both switches off at every transition.
// - in synchronous mode, low side off when sensed current drops below under-current level.
// - non-synchronous mode when average current or battery voltage low.
// - in non-synchronous mode low side only gives bootstrap refresh pulses.
// - leave non-synchronous mode when average current exceeds upper threshold.
// - input over-current past blanking opens adapter switches for hold-off, then soft-start.
// - seventh input over-current event in window latches adapter switches off.
// - event counter clears when the counting window elapses.
// - config bits 2:1 disable input over-current or pick one of three multiples.
// - charge peak over-current kills high side for rest of cycle.
// - peak over-current level chosen from three by programmed charge current.
// - battery over-voltage blocks turn-on of both switches.
// - over-voltage lasting past persistence time disables charging completely.
// - discharge sink on only while battery over-voltage is active.
// - battery low disables charging for fixed interval, then soft-start if enabled.
// - battery low limits current and keeps low side off apart from refresh.
// - thermal stop above upper trip, resume below lower point with soft-start.
// - config bit 9 enables frequency trim, bit 10 chooses its direction.
// - seventh short event latches charging off, opens adapter, closes battery switch.
// - config bits 8:7 choose the high-side short threshold code.
// - soft-start begins small and steps up each fixed interval to the limit.
package chg_pkg;
   localparam int CLK_HZ          = 10_000_000;
   localparam int DEAD_NS         = 100;
   localparam int DEAD_CYC        = (DEAD_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
   localparam int REFRESH_NS      = 200;
   localparam int REFRESH_CYC     = (REFRESH_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
   localparam int INPUT_OVERCURRENT_FAULT_BLANK_US   = 2500;
   localparam int INPUT_OVERCURRENT_FAULT_BLANK_CYC  = INPUT_OVERCURRENT_FAULT_BLANK_US * (CLK_HZ / 1_000_000);
   localparam int INPUT_OVERCURRENT_FAULT_HOLD_MS    = 1300;
   localparam int INPUT_OVERCURRENT_FAULT_HOLD_CYC   = INPUT_OVERCURRENT_FAULT_HOLD_MS * (CLK_HZ / 1000);
   localparam int INPUT_OVERCURRENT_FAULT_WIN_S      = 90;
   localparam longint INPUT_OVERCURRENT_FAULT_WIN_CYC = longint'(INPUT_OVERCURRENT_FAULT_WIN_S) * CLK_HZ;
   localparam int OVP_PERSIST_MS  = 30;
   localparam int OVP_PERSIST_CYC = OVP_PERSIST_MS * (CLK_HZ / 1000);
   localparam int BLOW_HOLD_MS    = 1;
   localparam int BLOW_HOLD_CYC   = BLOW_HOLD_MS * (CLK_HZ / 1000);
   localparam int SS_STEP_US      = 240;
   localparam int SS_STEP_CYC     = SS_STEP_US * (CLK_HZ / 1_000_000);
   localparam logic [2:0] EVENT_LIMIT = 3'h7;
   // current codes in 64 mA units
   localparam logic [7:0] SS_START_CODE = 8'h02;
   localparam logic [7:0] SS_STEP_CODE  = 8'h01;
   localparam logic [7:0] BLOW_LIM_CODE = 8'h08;
   localparam logic [7:0] OCP_BRK_LO    = 8'h40;
   localparam logic [7:0] OCP_BRK_HI    = 8'h60;
   // config field positions
   localparam int CFG_INPUT_OVERCURRENT_FAULT_LSB  = 1;
   localparam int CFG_HSSC_LSB  = 7;
   localparam int CFG_TRIM_EN   = 9;
   localparam int CFG_TRIM_UP   = 10;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   typedef enum {PH_IDLE, PH_HIGH, PH_DEAD_HL, PH_LOW, PH_DEAD_LH} phase_t;
   typedef struct packed {
      logic ramp_above_err;
      logic ramp_reset;
      logic under_current;
      logic avg_low;
      logic avg_high;
      logic boot_low;
      logic input_oc;
      logic charge_oc;
      logic bat_ov;
      logic bat_low;
      logic temp_hi;
      logic temp_lo;
      logic short_hs;
      logic short_ls;
      logic adapter_low;
      logic supply_uv;
   } sense_t;
   typedef struct packed {
      logic high_side_switch;
      logic low_side_switch;
      logic adapter_input_switch;
      logic battery_path_switch;
      logic discharge_sink;
   } drive_t;
endpackage

/* File: core/chg_ctrl.sv */
// charger switch sequencing and fault state machines
`timescale 1ns/1ps
module chg_ctrl import chg_pkg::*; #(
   parameter int HOLD_CYC   = INPUT_OVERCURRENT_FAULT_HOLD_CYC,
   parameter int WIN_CYC    = int'(INPUT_OVERCURRENT_FAULT_WIN_CYC),
   parameter int BLANK_CYC  = INPUT_OVERCURRENT_FAULT_BLANK_CYC,
   parameter int OVP_CYC    = OVP_PERSIST_CYC,
   parameter int BLOW_CYC   = BLOW_HOLD_CYC,
   parameter int SS_CYC     = SS_STEP_CYC
) (
   input  wire logic        MCLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CE_I,
   input  wire sense_t      SENSE_I,
   input  wire logic        CHARGE_EN_I,
   input  wire logic [3:0]  ADDR_I,
   input  wire logic [15:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic      [15:0] RDATA_O,
   output drive_t           DRIVE_O,
   output logic      [1:0]  INPUT_OVERCURRENT_FAULT_SEL_O,
   output logic      [1:0]  HS_SHORT_SEL_O,
   output logic      [1:0]  OCP_SEL_O,
   output logic             TRIM_EN_O,
   output logic             TRIM_UP_O,
   output logic      [7:0]  CUR_LIMIT_O
);
   localparam logic [3:0] A_CFG    = 4'h0;
   localparam logic [3:0] A_ICHG   = 4'h1;
   localparam logic [3:0] A_STATUS = 4'h2;

   sense_t      s1_q, s2_q;
   logic [15:0] cfg_q;
   logic [7:0]  ichg_q;
   phase_t      ph_q;
   logic [7:0]  dead_q;
   logic [7:0]  ref_q;
   logic        nsync_q;
   logic        ocp_cut_q;
   logic [31:0] blank_q, hold_q, win_q, ovp_q, blow_q, ss_q;
   logic        hold_act_q, input_overcurrent_fault_latch_q, ovp_off_q, blow_act_q, therm_q, sc_latch_q;
   logic [2:0]  input_overcurrent_fault_cnt_q, sc_cnt_q;
   logic [7:0]  ss_lim_q;
   logic        prev_run_q;
   logic        short_prev_q;
   logic        input_overcurrent_fault_ev, short_ev, run, clr_latch;
   logic [7:0]  lim_ok;

   // two-flop synchroniser for analog comparators
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (CE_I) begin
         s1_q <= SENSE_I;
         s2_q <= s1_q;
      end
   end

   // register port
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cfg_q  <= CFG_RESET;
         ichg_q <= 8'h00;
      end else if (CE_I && WR_I) begin
         if (ADDR_I == A_CFG) begin
            cfg_q <= WDATA_I;
         end else if (ADDR_I == A_ICHG) begin
            ichg_q <= WDATA_I[7:0];
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O <= 16'h0000;
      end else if (CE_I) begin
         if (!RD_I) begin
            RDATA_O <= 16'h0000;
         end else if (ADDR_I == A_CFG) begin
            RDATA_O <= cfg_q;
         end else if (ADDR_I == A_ICHG) begin
            RDATA_O <= {8'h00, ichg_q};
         end else if (ADDR_I == A_STATUS) begin
            RDATA_O <= {3'h0, nsync_q, sc_cnt_q, input_overcurrent_fault_cnt_q, sc_latch_q, input_overcurrent_fault_latch_q,
                        hold_act_q, ovp_off_q, blow_act_q, therm_q};
         end else begin
            RDATA_O <= 16'h0000;
         end
      end
   end

   assign INPUT_OVERCURRENT_FAULT_SEL_O     = cfg_q[CFG_INPUT_OVERCURRENT_FAULT_LSB +: 2];
   assign HS_SHORT_SEL_O = cfg_q[CFG_HSSC_LSB +: 2];
   assign TRIM_EN_O      = cfg_q[CFG_TRIM_EN];
   assign TRIM_UP_O      = cfg_q[CFG_TRIM_UP];
   assign OCP_SEL_O = (ichg_q < OCP_BRK_LO) ? 2'h0 : ((ichg_q < OCP_BRK_HI) ? 2'h1 : 2'h2);

   assign clr_latch = s2_q.adapter_low | s2_q.supply_uv;
   assign run = CHARGE_EN_I && !hold_act_q && !input_overcurrent_fault_latch_q && !ovp_off_q && !blow_act_q
                && !therm_q && !sc_latch_q && (ichg_q != 8'h00);

   // input over-current blanking, hold-off, counter, latch
   assign input_overcurrent_fault_ev = (blank_q == 32'(BLANK_CYC - 1)) && s2_q.input_oc && (cfg_q[CFG_INPUT_OVERCURRENT_FAULT_LSB +: 2] != 2'h0);
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         blank_q <= '0;
      end else if (CE_I) begin
         if (!s2_q.input_oc || hold_act_q || cfg_q[CFG_INPUT_OVERCURRENT_FAULT_LSB +: 2] == 2'h0) begin
            blank_q <= '0;
         end else if (blank_q < 32'(BLANK_CYC - 1)) begin
            blank_q <= blank_q + 32'h1;
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         hold_act_q <= 1'b0;
         hold_q     <= '0;
      end else if (CE_I) begin
         if (input_overcurrent_fault_ev && !hold_act_q) begin
            hold_act_q <= 1'b1;
            hold_q     <= '0;
         end else if (hold_act_q) begin
            if (hold_q == 32'(HOLD_CYC - 1)) begin
               hold_act_q <= 1'b0;
            end
            hold_q <= hold_q + 32'h1;
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         win_q      <= '0;
         input_overcurrent_fault_cnt_q <= 3'h0;
         input_overcurrent_fault_latch_q <= 1'b0;
      end else if (CE_I) begin
         // an event beats a coinciding clear so no fault is lost
         if (input_overcurrent_fault_ev && !hold_act_q) begin
            if (input_overcurrent_fault_cnt_q == EVENT_LIMIT - 3'h1) begin
               input_overcurrent_fault_latch_q <= 1'b1;
            end
            input_overcurrent_fault_cnt_q <= input_overcurrent_fault_cnt_q + 3'h1;
         end else if (s2_q.adapter_low) begin
            input_overcurrent_fault_latch_q <= 1'b0;
            input_overcurrent_fault_cnt_q   <= 3'h0;
         end else if (win_q == 32'(WIN_CYC - 1)) begin
            input_overcurrent_fault_cnt_q <= 3'h0;
         end
         if (s2_q.adapter_low || win_q == 32'(WIN_CYC - 1)) begin
            win_q <= '0;
         end else begin
            win_q <= win_q + 32'h1;
         end
      end
   end

   // battery over-voltage persistence; cleared by latch reset
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ovp_q     <= '0;
         ovp_off_q <= 1'b0;
      end else if (CE_I) begin
         if (!s2_q.bat_ov) begin
            ovp_q <= '0;
         end else if (ovp_q < 32'(OVP_CYC)) begin
            ovp_q <= ovp_q + 32'h1;
         end
         if (s2_q.bat_ov && ovp_q == 32'(OVP_CYC - 1)) begin
            ovp_off_q <= 1'b1;
         end else if (clr_latch) begin
            ovp_off_q <= 1'b0;
         end
      end
   end

   // battery-low pause
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         blow_q     <= '0;
         blow_act_q <= 1'b0;
      end else if (CE_I) begin
         if (s2_q.bat_low && !blow_act_q && blow_q == 32'h0) begin
            blow_act_q <= 1'b1;
            blow_q     <= 32'h1;
         end else if (blow_act_q) begin
            if (blow_q == 32'(BLOW_CYC)) begin
               blow_act_q <= 1'b0;
            end else begin
               blow_q <= blow_q + 32'h1;
            end
         end else if (!s2_q.bat_low) begin
            blow_q <= '0;
         end
      end
   end

   // thermal hysteresis
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         therm_q <= 1'b0;
      end else if (CE_I) begin
         if (s2_q.temp_hi) begin
            therm_q <= 1'b1;
         end else if (!s2_q.temp_lo) begin
            therm_q <= 1'b0;
         end
      end
   end

   // short event counting and latch
   assign short_ev = (s2_q.short_hs | s2_q.short_ls) && !short_prev_q;
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         short_prev_q <= 1'b0;
         sc_cnt_q     <= 3'h0;
         sc_latch_q   <= 1'b0;
      end else if (CE_I) begin
         short_prev_q <= s2_q.short_hs | s2_q.short_ls;
         if (short_ev && !sc_latch_q) begin
            if (sc_cnt_q == EVENT_LIMIT - 3'h1) begin
               sc_latch_q <= 1'b1;
            end
            sc_cnt_q <= sc_cnt_q + 3'h1;
         end else if (clr_latch) begin
            sc_cnt_q   <= 3'h0;
            sc_latch_q <= 1'b0;
         end
      end
   end

   // soft-start ramp of the current limit
   assign lim_ok = s2_q.bat_low ? BLOW_LIM_CODE : ichg_q;
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ss_q       <= '0;
         ss_lim_q   <= 8'h00;
         prev_run_q <= 1'b0;
      end else if (CE_I) begin
         prev_run_q <= run;
         if (!run) begin
            ss_lim_q <= 8'h00;
            ss_q     <= '0;
         end else if (!prev_run_q) begin
            ss_lim_q <= SS_START_CODE;
            ss_q     <= '0;
         end else if (ss_q == 32'(SS_CYC - 1)) begin
            ss_q <= '0;
            if (ss_lim_q < lim_ok) begin
               ss_lim_q <= ss_lim_q + SS_STEP_CODE;
            end
         end else begin
            ss_q <= ss_q + 32'h1;
         end
      end
   end
   assign CUR_LIMIT_O = (s2_q.bat_low && ss_lim_q > BLOW_LIM_CODE) ? BLOW_LIM_CODE : ss_lim_q;

   // synchronous / non-synchronous selection with hysteresis
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         nsync_q <= 1'b1;
      end else if (CE_I) begin
         if (s2_q.avg_low || s2_q.bat_low) begin
            nsync_q <= 1'b1;
         end else if (s2_q.avg_high) begin
            nsync_q <= 1'b0;
         end
      end
   end

   // switching phase machine with dead time
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ph_q      <= PH_IDLE;
         dead_q    <= 8'h00;
         ref_q     <= 8'h00;
         ocp_cut_q <= 1'b0;
      end else if (CE_I) begin
         if (s2_q.charge_oc) begin
            ocp_cut_q <= 1'b1;
         end else if (s2_q.ramp_reset) begin
            ocp_cut_q <= 1'b0;
         end
         case (ph_q)
            PH_IDLE: begin
               if (run && s2_q.ramp_reset && !s2_q.bat_ov) begin
                  ph_q <= PH_HIGH;
               end
            end
            PH_HIGH: begin
               if (!run || s2_q.ramp_above_err || s2_q.charge_oc || s2_q.bat_ov) begin
                  ph_q   <= PH_DEAD_HL;
                  dead_q <= 8'h00;
               end
            end
            PH_DEAD_HL: begin
               if (dead_q == 8'(DEAD_CYC - 1)) begin
                  ph_q  <= (run && !s2_q.bat_ov) ? PH_LOW : PH_IDLE;
                  ref_q <= 8'h00;
               end else begin
                  dead_q <= dead_q + 8'h01;
               end
            end
            PH_LOW: begin
               if (ref_q != 8'hFF) begin
                  ref_q <= ref_q + 8'h01;
               end
               if (!run || s2_q.ramp_reset || s2_q.bat_ov) begin
                  ph_q   <= PH_DEAD_LH;
                  dead_q <= 8'h00;
               end
            end
            PH_DEAD_LH: begin
               if (dead_q == 8'(DEAD_CYC - 1)) begin
                  ph_q <= (run && !s2_q.bat_ov && !ocp_cut_q) ? PH_HIGH : PH_IDLE;
               end else begin
                  dead_q <= dead_q + 8'h01;
               end
            end
            default: ph_q <= PH_IDLE;
         endcase
      end
   end

   // low side gating: under-current, refresh-only in non-synchronous mode
   logic ls_allow;
   always_comb begin
      ls_allow = !s2_q.under_current;
      if (nsync_q) begin
         ls_allow = s2_q.boot_low && (ref_q < 8'(REFRESH_CYC));
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         DRIVE_O <= '0;
      end else if (CE_I) begin
         DRIVE_O.high_side_switch <= (ph_q == PH_HIGH) && !ocp_cut_q && !s2_q.bat_ov;
         DRIVE_O.low_side_switch  <= (ph_q == PH_LOW) && ls_allow && !s2_q.bat_ov;
         DRIVE_O.adapter_input_switch <= !hold_act_q && !input_overcurrent_fault_latch_q && !sc_latch_q;
         DRIVE_O.battery_path_switch  <= sc_latch_q || input_overcurrent_fault_latch_q;
         DRIVE_O.discharge_sink       <= s2_q.bat_ov;
      end
   end

   property p_no_shoot;
      @(posedge MCLK_I) disable iff (!RST_N_I)
         !(DRIVE_O.high_side_switch && DRIVE_O.low_side_switch);
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("shoot through");
   property p_dead;
      @(posedge MCLK_I) disable iff (!RST_N_I)
         DRIVE_O.high_side_switch |=> !DRIVE_O.low_side_switch;
   endproperty
   a_dead: assert property (p_dead) else $error("no dead time");
   property p_ovp_block;
      @(posedge MCLK_I) disable iff (!RST_N_I)
         CE_I && s2_q.bat_ov |=> !DRIVE_O.high_side_switch && DRIVE_O.discharge_sink;
   endproperty
   a_ovp_block: assert property (p_ovp_block) else $error("ovp not blocking");
   property p_sink_off;
      @(posedge MCLK_I) disable iff (!RST_N_I)
         CE_I && !s2_q.bat_ov |=> !DRIVE_O.discharge_sink;
   endproperty
   a_sink_off: assert property (p_sink_off) else $error("sink on without ovp");
   property p_ls_nsync;
      @(posedge MCLK_I) disable iff (!RST_N_I)
         CE_I && nsync_q && !s2_q.boot_low |=> !DRIVE_O.low_side_switch;
   endproperty
   a_ls_nsync: assert property (p_ls_nsync) else $error("low side on without refresh");
   property p_sc_latch;
      @(posedge MCLK_I) disable iff (!RST_N_I)
         sc_latch_q && CE_I |=> !DRIVE_O.adapter_input_switch;
   endproperty
   a_sc_latch: assert property (p_sc_latch) else $error("short latch");
   property p_therm;
      @(posedge MCLK_I) disable iff (!RST_N_I)
         CE_I && s2_q.temp_hi |=> therm_q && !run;
   endproperty
   a_therm: assert property (p_therm) else $error("thermal");
   c_hold: cover property (@(posedge MCLK_I) hold_act_q);
   c_nsync: cover property (@(posedge MCLK_I) !nsync_q);
   c_latch: cover property (@(posedge MCLK_I) sc_latch_q);
endmodule // chg_ctrl

/* File: verif/chg_analog_model.sv */
// comparator and gate driver model at the power stage side
`timescale 1ns/1ps
module chg_analog_model #(
   parameter int PERIOD = 20,
   parameter int DUTY   = 10
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic ls_i,
   output logic      above_o,
   output logic      reset_o,
   output logic      uc_o,
   output logic      boot_o
);
   int ph_q;
   int on_q;
   int off_q;
   // counters move right after the edge, like a real comparator settling late
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ph_q  <= 0;
         on_q  <= 0;
         off_q <= 0;
      end else begin
         ph_q  <= (ph_q == PERIOD - 1) ? 0 : ph_q + 1;
         on_q  <= ls_i ? on_q + 1 : 0;
         off_q <= ls_i ? 0 : off_q + 1;
      end
   end
   assign above_o = (ph_q >= DUTY);
   assign reset_o = (ph_q == PERIOD - 1);
   // inductor drains a few cycles after the low side closes
   assign uc_o    = (on_q >= 4);
   // bootstrap sags only when the low side stays open long
   assign boot_o  = (off_q >= 40);
endmodule // chg_analog_model

/* File: verif/testbench.sv */
// self-checking bench for the charger switch and fault control
`timescale 1ns/1ps
module testbench import chg_pkg::*; ;
   localparam int T = 20;
   localparam int W = 2000;
   logic        mclk;
   logic        rst_n;
   logic        ce;
   logic        chg_en;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic [15:0] rv;
   logic [15:0] cv;
   sense_t      flt;
   sense_t      sns;
   drive_t      drv;
   logic [1:0]  input_overcurrent_fault_sel;
   logic [1:0]  hs_sel;
   logic [1:0]  ocp_sel;
   logic        trim_en;
   logic        trim_up;
   logic [7:0]  cur_lim;
   logic        above;
   logic        rreset;
   logic        ucur;
   logic        boot;
   logic        ph;
   logic        pl;
   int          fail_count;
   int          n_checks;
   int          hs_on;
   int          ls_on;
   int          run;
   int          mx;
   int          bad;
   int          k;
   always_comb begin
      sns = flt;
      sns.ramp_above_err = above;
      sns.ramp_reset = rreset;
      sns.under_current = ucur;
      sns.boot_low = boot;
   end
   chg_ctrl #(.HOLD_CYC(T), .WIN_CYC(W), .BLANK_CYC(T), .OVP_CYC(T), .BLOW_CYC(T), .SS_CYC(T)) dut (
      .MCLK_I(mclk), .RST_N_I(rst_n), .CE_I(ce), .SENSE_I(sns), .CHARGE_EN_I(chg_en),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DRIVE_O(drv),
      .INPUT_OVERCURRENT_FAULT_SEL_O(input_overcurrent_fault_sel), .HS_SHORT_SEL_O(hs_sel), .OCP_SEL_O(ocp_sel),
      .TRIM_EN_O(trim_en), .TRIM_UP_O(trim_up), .CUR_LIMIT_O(cur_lim));
   chg_analog_model #(.PERIOD(20), .DUTY(10)) partner (
      .clk_i(mclk), .rst_n_i(rst_n), .ls_i(drv.low_side_switch),
      .above_o(above), .reset_o(rreset), .uc_o(ucur), .boot_o(boot));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic endt(input string nm);
      $display("test %s finished, mismatches so far %0d", nm, fail_count);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // counts on-cycles, longest low-side run and overlap or missing dead time
   task automatic watch(input int n);
      hs_on = 0;
      ls_on = 0;
      run = 0;
      mx = 0;
      bad = 0;
      ph = drv.high_side_switch;
      pl = drv.low_side_switch;
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (drv.high_side_switch & (drv.low_side_switch | pl)) bad++;
         if (drv.low_side_switch & ph) bad++;
         hs_on += drv.high_side_switch;
         ls_on += drv.low_side_switch;
         run = drv.low_side_switch ? run + 1 : 0;
         mx = (run > mx) ? run : mx;
         ph = drv.high_side_switch;
         pl = drv.low_side_switch;
      end
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      fail_count = 0;
      n_checks = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      chg_en = 1'b1;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      flt = '0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      rd_reg(4'h0, rv);
      chk("cfg_reset", rv, CFG_RESET);
      rd_reg(4'h2, rv);
      chk("status_reset", rv, 16'h1000);
      wr_reg(4'hF, 16'hFFFF);
      rd_reg(4'hF, rv);
      chk("unmapped", rv, 16'h0000);
      for (k = 0; k < 4; k++) begin
         cv = (16'(k) << CFG_INPUT_OVERCURRENT_FAULT_LSB) | (16'(k) << CFG_HSSC_LSB) | (16'(k) << CFG_TRIM_EN);
         wr_reg(4'h0, cv);
         rd_reg(4'h0, rv);
         chk("cfg_read", rv, cv);
         chk("input_overcurrent_fault_sel", input_overcurrent_fault_sel, 16'(k));
         chk("hs_short_sel", hs_sel, 16'(k));
         chk("trim", {trim_up, trim_en}, 16'(k));
      end
      endt("config");
      for (k = 0; k < 3; k++) begin
         wr_reg(4'h1, 16'h0020 + 16'(k) * 16'h0028);
         cyc(2);
         chk("ocp_sel", ocp_sel, 16'(k));
      end
      endt("ocp_level");
      @(posedge mclk);
      chg_en <= 1'b0;
      wr_reg(4'h1, 16'h000C);
      cyc(6);
      @(posedge mclk);
      chg_en <= 1'b1;
      for (k = 0; k < 40 && cur_lim === 8'h00; k++) cyc(1);
      chk("ss_first", cur_lim, SS_START_CODE);
      for (k = 0; k < 14 * T && cur_lim !== 8'h0C; k++) cyc(1);
      chk("ss_held", k >= 9 * T, 1);
      chk("ss_final", cur_lim, 16'h000C);
      endt("soft_start");
      @(posedge mclk);
      flt.avg_high <= 1'b1;
      cyc(6);
      @(posedge mclk);
      flt.avg_high <= 1'b0;
      rd_reg(4'h2, rv);
      chk("sync_mode", rv[12], 0);
      watch(100);
      chk("hs_switching", hs_on > 20, 1);
      chk("ls_switching", ls_on > 10, 1);
      chk("uc_cut", mx <= 8, 1);
      chk("dead_time", bad, 0);
      @(posedge mclk);
      flt.charge_oc <= 1'b1;
      watch(80);
      chk("oc_cut", hs_on <= 16, 1);
      @(posedge mclk);
      flt.charge_oc <= 1'b0;
      watch(80);
      chk("oc_resume", hs_on > 24, 1);
      @(posedge mclk);
      flt.avg_low <= 1'b1;
      cyc(6);
      rd_reg(4'h2, rv);
      chk("nsync_mode", rv[12], 1);
      watch(200);
      chk("refresh", ls_on > 0 && ls_on <= 16, 1);
      chk("dead_nsync", bad, 0);
      @(posedge mclk);
      flt.avg_low <= 1'b0;
      endt("switching");
      @(posedge mclk);
      flt.bat_ov <= 1'b1;
      cyc(4);
      watch(16);
      chk("ov_block", hs_on + ls_on, 0);
      chk("ov_sink", drv.discharge_sink, 1);
      cyc(T);
      rd_reg(4'h2, rv);
      chk("ov_off", rv[2], 1);
      @(posedge mclk);
      flt.bat_ov <= 1'b0;
      cyc(4);
      chk("sink_off", drv.discharge_sink, 0);
      watch(40);
      chk("ov_disabled", hs_on, 0);
      @(posedge mclk);
      flt.adapter_low <= 1'b1;
      cyc(4);
      @(posedge mclk);
      flt.adapter_low <= 1'b0;
      endt("overvoltage");
      @(posedge mclk);
      flt.bat_low <= 1'b1;
      cyc(4);
      rd_reg(4'h2, rv);
      chk("blow_pause", rv[1], 1);
      chk("ov_cleared", rv[2], 0);
      watch(8);
      chk("blow_off", hs_on, 0);
      cyc(14 * T);
      chk("blow_limit", cur_lim, BLOW_LIM_CODE);
      rd_reg(4'h2, rv);
      chk("blow_nsync", rv[12:11], 16'h0002);
      @(posedge mclk);
      flt.bat_low <= 1'b0;
      endt("battery_low");
      @(posedge mclk);
      flt.temp_hi <= 1'b1;
      cyc(4);
      watch(30);
      chk("thermal_stop", hs_on, 0);
      rd_reg(4'h2, rv);
      chk("thermal_flag", rv[0], 1);
      // lower-point sense high keeps the stop and low releases it; both levels are visited
      @(posedge mclk);
      flt.temp_hi <= 1'b0;
      flt.temp_lo <= 1'b1;
      cyc(6);
      rd_reg(4'h2, rv);
      chk("thermal_hold", rv[0], 1);
      @(posedge mclk);
      flt.temp_lo <= 1'b0;
      cyc(6);
      rd_reg(4'h2, rv);
      chk("thermal_clear", rv[0], 0);
      endt("thermal");
      wr_reg(4'h0, 16'h0002);
      for (k = 1; k <= 7; k++) begin
         @(posedge mclk);
         flt.input_oc <= 1'b1;
         cyc(T + 6);
         chk("input_overcurrent_fault_open", drv.adapter_input_switch, 0);
         @(posedge mclk);
         flt.input_oc <= 1'b0;
         cyc(T + 6);
         rd_reg(4'h2, rv);
         if (k < 7) chk("input_overcurrent_fault_count", rv[8:6], 16'(k));
         chk("input_overcurrent_fault_latch", rv[4], k == 7);
         chk("input_overcurrent_fault_back", drv.adapter_input_switch, k != 7);
      end
      @(posedge mclk);
      flt.adapter_low <= 1'b1;
      cyc(4);
      @(posedge mclk);
      flt.adapter_low <= 1'b0;
      cyc(4);
      rd_reg(4'h2, rv);
      chk("input_overcurrent_fault_unlatch", rv[4], 0);
      wr_reg(4'h0, 16'h0000);
      @(posedge mclk);
      flt.input_oc <= 1'b1;
      cyc(T + 6);
      chk("input_overcurrent_fault_disabled", drv.adapter_input_switch, 1);
      @(posedge mclk);
      flt.input_oc <= 1'b0;
      wr_reg(4'h0, 16'h0002);
      @(posedge mclk);
      flt.input_oc <= 1'b1;
      cyc(T + 6);
      @(posedge mclk);
      flt.input_oc <= 1'b0;
      cyc(W + 100);
      rd_reg(4'h2, rv);
      chk("input_overcurrent_fault_window", rv[8:6], 0);
      endt("input_overcurrent");
      for (k = 0; k < 7; k++) begin
         @(posedge mclk);
         flt.short_hs <= 1'b1;
         cyc(3);
         @(posedge mclk);
         flt.short_hs <= 1'b0;
         cyc(4);
         rd_reg(4'h2, rv);
         chk("short_latch", rv[5], k == 6);
      end
      chk("short_adapter", drv.adapter_input_switch, 0);
      chk("short_battery", drv.battery_path_switch, 1);
      watch(30);
      chk("short_stop", hs_on, 0);
      @(posedge mclk);
      flt.supply_uv <= 1'b1;
      cyc(4);
      @(posedge mclk);
      flt.supply_uv <= 1'b0;
      cyc(4);
      rd_reg(4'h2, rv);
      chk("short_clear", rv[5], 0);
      endt("short");
      report_and_stop();
   end
endmodule // testbench
